// File: ripc_regs.svh
// Constants for the reset, idle and power-down controller
`ifndef RIPC_REGS_SVH
`define RIPC_REGS_SVH
`define RIPC_RST_QUAL_OSC 24
`define RIPC_OSC_PER_STROBE 6
`define RIPC_STROBE_CNT_W 3
`define RIPC_QUAL_CNT_W 5
`define RIPC_ROM_LIMIT 16'h2000
`define RIPC_WDT_PULSE_OSC 24
`define RIPC_PWR_IDLE_BIT 0
`define RIPC_PWR_PD_BIT 1
`endif

// File: ripc_pkg.sv
// Types shared by the reset, idle and power-down controller
`default_nettype none
package ripc_pkg;
  typedef enum logic [1:0] {
    RIPC_RUN = 2'b00,
    RIPC_IDLE = 2'b01,
    RIPC_PDOWN = 2'b10,
    RIPC_RESET = 2'b11
  } ripc_mode_t;
  // Pin levels that depend on the operating mode
  typedef struct packed {
    logic addr_strobe;
    logic program_fetch_strobe;
    logic port0_float;
    logic port2_addr;
    logic pulse_high;
  } ripc_pins_t;
endpackage
`default_nettype wire

// File: ripc_ctrl.sv
// Reset, idle and power-down controller with bus strobe and pin-state control
//
// Overview of operation
// - Reset needs pin high 24 oscillator periods
// - Internal clock via divide-by-two flip-flop
// - Address strobe pulses every six periods
// - Skip one strobe per external data access
// - Fetch internal below 8192 when select high
// - Port 0 pulls up only on bus
// - Mode begins after requesting instruction
// - Mode bits from power control register
// - Idle halts CPU, peripherals keep running
// - Idle ends on interrupt or reset
// - Power-down stops oscillator, keeps RAM
// - Power-down ends only on reset
// - Pin levels fixed in low-power modes
// - Watchdog overflow pulses reset pin out
// - Watchdog enable blocks power-down entry
`include "ripc_regs.svh"
`default_nettype none
module ripc_ctrl
  import ripc_pkg::*;
(
  input wire logic mclk, // Oscillator input clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic rst_pin_in, // Reset pin level seen at the pad
  input wire logic watchdog_overflow, // Watchdog timer overflow pulse
  input wire logic watchdog_enable_input, // Watchdog enable strap
  input wire logic external_fetch_select, // High allows internal ROM fetch
  input wire logic [15:0] pc, // Program counter of the CPU
  input wire logic [7:0] power_control_register, // Power control bits from the CPU
  input wire logic power_control_write, // Instruction writing power control completes
  input wire logic irq_pending, // Any enabled interrupt requested
  input wire logic ext_data_access, // External data access in this machine cycle
  input wire logic ext_bus_active, // Port 0 acts as the address/data bus
  input wire logic [7:0] port0_out, // Port 0 output latch or bus value
  output logic clk_div2, // Divided internal clock
  output logic internal_reset, // Reset to CPU and peripherals
  output logic rst_pin_out, // Reset pin drive value
  output logic rst_pin_oe, // Reset pin output enable
  output logic cpu_halt, // CPU clock gate off
  output logic osc_stop, // Oscillator stop request
  output logic fetch_internal, // Code fetch from internal ROM
  output logic [7:0] port0_oe, // Port 0 output enables
  output logic [7:0] port0_o, // Port 0 output values
  output var ripc_pins_t pins, // Mode-dependent strobe and pin levels
  output var ripc_mode_t mode // Present operating mode
);
  // ==========================================================
  // Internal clock divider and machine-cycle phase
  logic div; // Divide-by-two flip-flop
  logic [`RIPC_STROBE_CNT_W-1:0] phase; // Oscillator period within strobe slot
  logic slot_end; // Last period of six
  logic skip; // Strobe suppressed this slot
  logic mc_half; // Toggles each strobe slot, marks machine cycle
  assign slot_end = (phase == 3'(`RIPC_OSC_PER_STROBE - 1));
  // Divider and phase counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div <= 1'b0;
      phase <= 3'h0;
      mc_half <= 1'b0;
    end else begin
      div <= ~div;
      phase <= slot_end ? 3'h0 : phase + 3'h1;
      if (slot_end) begin
        mc_half <= ~mc_half;
      end
    end
  end
  // ==========================================================
  // Reset pin qualification and watchdog pulse
  logic rs1, rs2; // Synchroniser stages
  logic [`RIPC_QUAL_CNT_W-1:0] qual; // High periods seen
  logic [`RIPC_QUAL_CNT_W-1:0] wdt_cnt; // Outgoing pulse length
  logic qualified; // Pin held long enough
  logic next_reset; // Next internal reset
  assign qualified = (qual == 5'(`RIPC_RST_QUAL_OSC - 1)) && rs2;
  assign next_reset = qualified | (internal_reset & (rs2 | ~(slot_end & mc_half)));
  // Synchroniser and counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rs1 <= 1'b0;
      rs2 <= 1'b0;
      qual <= 5'h0;
      internal_reset <= 1'b1;
      wdt_cnt <= 5'h0;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b0;
    end else begin
      rs1 <= rst_pin_in;
      rs2 <= rs1;
      if (!rs2) begin
        qual <= 5'h0;
      end else if (!qualified) begin
        qual <= qual + 5'h1;
      end
      internal_reset <= next_reset;
      if (watchdog_overflow && watchdog_enable_input) begin
        wdt_cnt <= 5'(`RIPC_WDT_PULSE_OSC);
      end else if (wdt_cnt != 5'h0) begin
        wdt_cnt <= wdt_cnt - 5'h1;
      end
      rst_pin_out <= (wdt_cnt != 5'h0);
      rst_pin_oe <= (wdt_cnt != 5'h0);
    end
  end
  // ==========================================================
  // Mode state machine
  ripc_mode_t next_mode;
  logic req_idle, req_pd; // Decoded power control requests
  assign req_idle = power_control_write & power_control_register[`RIPC_PWR_IDLE_BIT];
  assign req_pd = power_control_write & power_control_register[`RIPC_PWR_PD_BIT] & ~watchdog_enable_input;
  // Next mode
  always_comb begin
    next_mode = mode;
    unique case (mode)
      RIPC_RESET: next_mode = internal_reset ? RIPC_RESET : RIPC_RUN;
      RIPC_RUN: begin
        if (req_pd) begin
          next_mode = RIPC_PDOWN;
        end else if (req_idle) begin
          next_mode = RIPC_IDLE;
        end
      end
      RIPC_IDLE: next_mode = irq_pending ? RIPC_RUN : RIPC_IDLE;
      RIPC_PDOWN: next_mode = RIPC_PDOWN;
    endcase
    if (internal_reset) begin
      next_mode = RIPC_RESET;
    end
  end
  // Mode register and mode outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode <= RIPC_RESET;
      cpu_halt <= 1'b1;
      osc_stop <= 1'b0;
    end else begin
      mode <= next_mode;
      cpu_halt <= (next_mode != RIPC_RUN);
      osc_stop <= (next_mode == RIPC_PDOWN);
    end
  end
  // ==========================================================
  // Fetch source, strobes and pins
  logic is_int; // Fetch from internal ROM
  logic strobe_now; // Address strobe in run mode
  ripc_pins_t next_pins;
  assign is_int = external_fetch_select & (pc < `RIPC_ROM_LIMIT);
  assign skip = ext_data_access & mc_half;
  assign strobe_now = (phase < 3'h2) & ~skip;
  assign next_pins.addr_strobe = (mode == RIPC_IDLE) | ((mode == RIPC_RUN) & strobe_now);
  assign next_pins.program_fetch_strobe = (mode == RIPC_IDLE) | ((mode == RIPC_RUN) & (is_int | phase < 3'h3));
  assign next_pins.port0_float = (mode == RIPC_IDLE || mode == RIPC_PDOWN) & ~is_int;
  assign next_pins.port2_addr = (mode == RIPC_IDLE) & ~is_int;
  assign next_pins.pulse_high = (mode == RIPC_IDLE) | (mode == RIPC_PDOWN);
  // Pin registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_div2 <= 1'b0;
      fetch_internal <= 1'b0;
      pins <= '0;
      port0_oe <= 8'h00;
      port0_o <= 8'h00;
    end else begin
      clk_div2 <= div;
      fetch_internal <= is_int;
      pins <= next_pins;
      port0_o <= port0_out;
      port0_oe <= next_pins.port0_float ? 8'h00 : (ext_bus_active ? 8'hff : ~port0_out);
    end
  end
  // ==========================================================
  // Assertions
  property p_pd_only_reset;
    @(posedge mclk) disable iff (!nrst) (mode == RIPC_PDOWN && !internal_reset) |=> mode == RIPC_PDOWN;
  endproperty
  a_pd_only_reset: assert property (p_pd_only_reset) else $error("Power-down left without reset");
  property p_wd_blocks_pd;
    @(posedge mclk) disable iff (!nrst) (mode == RIPC_RUN && watchdog_enable_input && !internal_reset) |=> mode != RIPC_PDOWN;
  endproperty
  a_wd_blocks_pd: assert property (p_wd_blocks_pd) else $error("Power-down entered with watchdog");
  property p_idle_irq;
    @(posedge mclk) disable iff (!nrst) (mode == RIPC_IDLE && irq_pending && !internal_reset) |=> mode == RIPC_RUN;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("Idle not left on interrupt");
  property p_idle_pins;
    @(posedge mclk) disable iff (!nrst) mode == RIPC_IDLE |=> pins.addr_strobe && pins.program_fetch_strobe;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("Strobes not high in idle");
  property p_pd_pins;
    @(posedge mclk) disable iff (!nrst) mode == RIPC_PDOWN |=> !pins.addr_strobe && !pins.program_fetch_strobe;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("Strobes not low in power-down");
  property p_rst_qual;
    @(posedge mclk) disable iff (!nrst) (!internal_reset && !rs2) |=> !internal_reset;
  endproperty
  a_rst_qual: assert property (p_rst_qual) else $error("Reset without qualified pin");
  property p_fetch;
    @(posedge mclk) disable iff (!nrst) (!external_fetch_select) |=> !fetch_internal;
  endproperty
  a_fetch: assert property (p_fetch) else $error("Internal fetch with select low");
  property p_div;
    @(posedge mclk) disable iff (!nrst) clk_div2 |=> !clk_div2;
  endproperty
  a_div: assert property (p_div) else $error("Divider not toggling");
  property p_wdt;
    @(posedge mclk) disable iff (!nrst) (watchdog_overflow && watchdog_enable_input) |=> ##1 rst_pin_out && rst_pin_oe;
  endproperty
  a_wdt: assert property (p_wdt) else $error("No reset pulse on overflow");
  // Power-down always stops the oscillator and halts the CPU
  property p_pd_halt;
    @(posedge mclk) disable iff (!nrst) mode == RIPC_PDOWN |-> osc_stop && cpu_halt;
  endproperty
  a_pd_halt: assert property (p_pd_halt) else $error("Oscillator running in power-down");
  // Idle halts the CPU but keeps the oscillator for the peripherals
  property p_idle_halt;
    @(posedge mclk) disable iff (!nrst) mode == RIPC_IDLE |-> cpu_halt && !osc_stop;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("CPU running in idle");
  c_idle: cover property (@(posedge mclk) mode == RIPC_IDLE ##1 mode == RIPC_RUN);
  c_rst_release: cover property (@(posedge mclk) internal_reset ##1 !internal_reset);
  c_pd: cover property (@(posedge mclk) mode == RIPC_PDOWN);
  c_wdt: cover property (@(posedge mclk) rst_pin_oe);
endmodule
`default_nettype wire

// File: ripc_ext_mem.sv
// External memory model that latches the low address byte on each strobe
`default_nettype none
module ripc_ext_mem
  import ripc_pkg::*;
(
  input wire logic mclk, // Oscillator clock
  input wire logic nrst, // Reset, active low
  input wire ripc_pins_t pins, // Strobe levels from the controller
  input wire logic [7:0] port0_o, // Multiplexed address and data bus
  output logic [7:0] addr_lo // Latched low address byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic strobe_prev; // Strobe level seen at the last edge
  // ========================================
  // Address latch closes when the strobe falls
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strobe_prev <= 1'b0;
      addr_lo <= 8'h00;
    end else begin
      strobe_prev <= pins.addr_strobe;
      if (strobe_prev && !pins.addr_strobe) begin
        addr_lo <= port0_o;
      end
    end
  end
endmodule
`default_nettype wire

// File: reset_idle_powerdown_control_tb_top.sv
// Self-checking bench for the reset, idle and power-down controller
`default_nettype none
module reset_idle_powerdown_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ripc_pkg::*;
  logic mclk = 1'b0, nrst, rst_pin_in, watchdog_overflow, watchdog_enable_input, external_fetch_select;
  logic [15:0] pc;
  logic [7:0] power_control_register, port0_out, port0_oe, port0_o, addr_lo, v;
  logic power_control_write, irq_pending, ext_data_access, ext_bus_active;
  logic clk_div2, internal_reset, rst_pin_out, rst_pin_oe, cpu_halt, osc_stop, fetch_internal, d;
  ripc_pins_t pins;
  ripc_mode_t mode;
  logic [15:0] q[$]; // Expected results waiting for the monitor
  logic [15:0] got, exp_v;
  int errors = 0, tests_run = 0, n, r;
  event look;
  // ========================================
  // Clock
  always #25 mclk = ~mclk;
  ripc_ctrl ripc_ctrl_i (.mclk(mclk), .nrst(nrst), .rst_pin_in(rst_pin_in),
    .watchdog_overflow(watchdog_overflow), .watchdog_enable_input(watchdog_enable_input),
    .external_fetch_select(external_fetch_select), .pc(pc), .power_control_register(power_control_register),
    .power_control_write(power_control_write), .irq_pending(irq_pending), .ext_data_access(ext_data_access),
    .ext_bus_active(ext_bus_active), .port0_out(port0_out), .clk_div2(clk_div2),
    .internal_reset(internal_reset), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .cpu_halt(cpu_halt),
    .osc_stop(osc_stop), .fetch_internal(fetch_internal), .port0_oe(port0_oe), .port0_o(port0_o),
    .pins(pins), .mode(mode));
  ripc_ext_mem ripc_ext_mem_i (.mclk(mclk), .nrst(nrst), .pins(pins), .port0_o(port0_o), .addr_lo(addr_lo));
  // ========================================
  // Monitor takes the oldest note when a result is shown
  always @(look) begin
    exp_v = q.pop_front();
    tests_run++;
    if (got !== exp_v) begin
      errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp_v, got);
    end
  end
  task chk(input logic [15:0] e, input logic [15:0] g);
    q.push_back(e);
    got = g;
    ->look;
    #0;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task tally_and_finish;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function logic [15:0] obs(input int k);
    case (k)
      0: return {15'h0, internal_reset};
      1: return {14'h0, mode};
      default: return {15'h0, rst_pin_oe};
    endcase
  endfunction
  // Bounded wait for a watched output to reach a value
  task wait_until(input int k, input logic [15:0] e, input int lim);
    int i;
    for (i = 0; i < lim && obs(k) !== e; i++) cyc(1);
    if (obs(k) !== e) begin
      errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, obs(k));
      tally_and_finish();
    end
  endtask
  // Counts strobe rises over ten slots
  task count_strobes;
    logic prev;
    n = 0;
    prev = pins.addr_strobe;
    repeat (60) begin
      cyc(1);
      if (pins.addr_strobe && !prev) n++;
      prev = pins.addr_strobe;
    end
  endtask
  task write_power_control(input logic [7:0] b);
    power_control_register = b;
    power_control_write = 1'b1;
    cyc(1);
    power_control_write = 1'b0;
  endtask
  // ========================================
  // Main sequence
  initial begin
    {nrst, rst_pin_in, watchdog_overflow, watchdog_enable_input, power_control_write, irq_pending} = 6'h10;
    {ext_data_access, ext_bus_active, power_control_register, port0_out, pc} = 34'h0;
    external_fetch_select = 1'b1;
    r = $urandom(32'h12ce7c82);
    cyc(5);
    nrst = 1'b1;
    cyc(30);
    chk(16'h1, {15'h0, internal_reset});
    rst_pin_in = 1'b0;
    wait_until(0, 16'h0, 20);
    rst_pin_in = 1'b1;
    cyc(20);
    rst_pin_in = 1'b0;
    cyc(4);
    chk(16'h0, {15'h0, internal_reset});
    rst_pin_in = 1'b1;
    cyc(23);
    chk(16'h0, {15'h0, internal_reset});
    wait_until(0, 16'h1, 10);
    rst_pin_in = 1'b0;
    wait_until(0, 16'h0, 40);
    d = clk_div2;
    cyc(1);
    chk({15'h0, ~d}, {15'h0, clk_div2});
    v = 8'($urandom);
    port0_out = v;
    ext_bus_active = 1'b1;
    cyc(6);
    count_strobes();
    chk(16'd10, 16'(n));
    chk({8'h0, v}, {8'h0, addr_lo});
    chk({v, 8'hff}, {port0_o, port0_oe});
    ext_data_access = 1'b1;
    count_strobes();
    chk(16'd5, 16'(n));
    {ext_data_access, ext_bus_active} = 2'b00;
    cyc(2);
    chk({8'h0, ~v}, {8'h0, port0_oe});
    for (int i = 0; i < 4; i++) begin
      external_fetch_select = i[1];
      pc = i[0] ? 16'($urandom % 32'h2000) : 16'(32'h2000 + $urandom % 32'he000);
      cyc(2);
      chk({15'h0, i[1] & i[0]}, {15'h0, fetch_internal});
    end
    write_power_control(8'h01);
    chk({13'h0, RIPC_IDLE, 1'b1}, {13'h0, mode, cpu_halt});
    cyc(1);
    chk(16'h19, {11'h0, pins});
    irq_pending = 1'b1;
    cyc(1);
    irq_pending = 1'b0;
    chk({14'h0, RIPC_RUN}, {14'h0, mode});
    watchdog_enable_input = 1'b1;
    write_power_control(8'h02);
    cyc(1);
    chk({14'h0, RIPC_RUN}, {14'h0, mode});
    watchdog_overflow = 1'b1;
    cyc(1);
    watchdog_overflow = 1'b0;
    cyc(2);
    chk(16'h3, {14'h0, rst_pin_out, rst_pin_oe});
    wait_until(2, 16'h0, 40);
    watchdog_enable_input = 1'b0;
    external_fetch_select = 1'b0;
    write_power_control(8'h03);
    chk({13'h0, RIPC_PDOWN, 1'b1}, {13'h0, mode, osc_stop});
    cyc(1);
    chk(16'h5, {11'h0, pins});
    chk(16'h0, {8'h0, port0_oe});
    irq_pending = 1'b1;
    cyc(4);
    chk({14'h0, RIPC_PDOWN}, {14'h0, mode});
    irq_pending = 1'b0;
    rst_pin_in = 1'b1;
    wait_until(1, {14'h0, RIPC_RESET}, 30);
    rst_pin_in = 1'b0;
    wait_until(1, {14'h0, RIPC_RUN}, 40);
    tally_and_finish();
  end
endmodule
`default_nettype wire
